/* File: rotate_defines.vh */
// Constants for the rotate unit: opcodes, bit positions, register file size
`ifndef ROTATE_DEFINES_VH
`define ROTATE_DEFINES_VH
`define OP_NONE       2'h0
`define OP_LEFT_CARRY 2'h1
`define OP_RIGHT_CIRC 2'h2
`define OP_LEFT_CIRC  2'h3
`define MSB_BIT       7
`define LSB_BIT       0
`define ZERO_BYTE     8'h00
`define REG_IDX_W     2
`define NUM_REGS      4
`endif

/* File: rotate_left_carry_right_unit.v */
// Rotate unit: rotate left through carry and rotate right, with register file and flags
// Notes on behaviour
// [RL1] Left-through-carry result is low seven bits, carry in
// [RL2] Left-through-carry loads carry from old bit 7
// [RL3] Zero flag set when 8-bit result zero
// [RL4] Negative flag equals result bit 7
// [RL5] Rotate right moves old bit 0 to 7
// [RL6] Rotate right loads carry from old bit 0
// [RL7] Zero flag reflects only last byte result
// [RL8] Operand is general register, written back same
`timescale 1ns/1ps
`include "rotate_defines.vh"

module rotate_left_carry_right_unit #(
  parameter WIDTH = 8,
  parameter NREGS = `NUM_REGS,
  parameter IDXW  = `REG_IDX_W
) (
  input  wire             mclk,        // Core clock, 10 MHz
  input  wire             nrst,        // Synchronous reset, active low
  input  wire             op_valid,    // One-cycle instruction strobe
  input  wire [1:0]       op_code,     // Instruction select
  input  wire [IDXW-1:0]  op_reg,      // General register operand index
  input  wire             wr_en,       // Direct register load strobe
  input  wire [IDXW-1:0]  wr_reg,      // Direct load register index
  input  wire [WIDTH-1:0] wr_data,     // Direct load data
  input  wire [IDXW-1:0]  rd_reg,      // Read-back register index
  output reg  [WIDTH-1:0] rd_data,     // Registered read-back data
  output reg  [WIDTH-1:0] result,      // Last rotate result
  output reg              done,        // One-cycle pulse after rotate
  output reg              carry_flag,  // Carry flag
  output reg              zero_flag,   // Zero flag
  output reg              neg_flag     // Negative flag
);

  // ==========================================================
  // Constants
  // Bit positions follow the width so a wider datapath keeps the rules
  localparam MSB = WIDTH - 1;
  localparam LSB = `LSB_BIT;
  localparam [WIDTH-1:0] ALL_ZERO = {WIDTH{1'b0}};

  // ==========================================================
  // Helper functions
  // Shift up one place, fill bit enters at the bottom
  function [WIDTH-1:0] shift_in_low;
    input [WIDTH-1:0] value;
    input             fill;
    begin
      shift_in_low = {value[MSB-1:LSB], fill};
    end
  endfunction

  // Shift down one place, fill bit enters at the top
  function [WIDTH-1:0] shift_in_high;
    input [WIDTH-1:0] value;
    input             fill;
    begin
      shift_in_high = {fill, value[MSB:LSB+1]};
    end
  endfunction

  // Rotated byte for the selected code; a code that is no rotate passes the operand
  function [WIDTH-1:0] rotate_value;
    input [1:0]       code;
    input [WIDTH-1:0] value;
    input             carry_in;
    begin
      case (code)
        `OP_LEFT_CARRY: begin
          rotate_value = shift_in_low(value, carry_in);  // [RL1]
        end
        `OP_RIGHT_CIRC: begin
          rotate_value = shift_in_high(value, value[LSB]);  // [RL5]
        end
        `OP_LEFT_CIRC: begin
          // Plain left rotate kept so byte pairs can chain into wider rotates
          rotate_value = shift_in_low(value, value[MSB]);
        end
        default: begin
          rotate_value = value;
        end
      endcase
    end
  endfunction

  // Carry after the selected code; a code that is no rotate keeps the old carry
  function carry_out;
    input [1:0]       code;
    input [WIDTH-1:0] value;
    input             carry_in;
    begin
      case (code)
        `OP_LEFT_CARRY: begin
          carry_out = value[MSB];  // [RL2]
        end
        `OP_RIGHT_CIRC: begin
          carry_out = value[LSB];  // [RL6]
        end
        `OP_LEFT_CIRC: begin
          carry_out = value[MSB];
        end
        default: begin
          carry_out = carry_in;
        end
      endcase
    end
  endfunction

  // One of the three rotates is selected
  function is_rotate_code;
    input [1:0] code;
    begin
      case (code)
        `OP_LEFT_CARRY: is_rotate_code = 1'b1;
        `OP_RIGHT_CIRC: is_rotate_code = 1'b1;
        `OP_LEFT_CIRC:  is_rotate_code = 1'b1;
        default:        is_rotate_code = 1'b0;
      endcase
    end
  endfunction

  // Whole byte is clear
  function is_zero;
    input [WIDTH-1:0] value;
    begin
      is_zero = (value == ALL_ZERO);
    end
  endfunction

  // ==========================================================
  // Datapath signals
  reg  [WIDTH-1:0] general_register_operand [0:NREGS-1];
  wire [WIDTH-1:0] operand;
  wire [WIDTH-1:0] next_rd_data;
  wire             take;
  reg  [WIDTH-1:0] next_result;
  reg              next_carry;
  reg              next_zero;
  reg              next_neg;
  integer          i;

  // Operand comes from the register named by the instruction itself
  assign operand      = general_register_operand[op_reg];  // [RL8]
  assign next_rd_data = general_register_operand[rd_reg];
  assign take         = op_valid && is_rotate_code(op_code);

  // ==========================================================
  // Rotate datapath
  always @* begin
    next_result = rotate_value(op_code, operand, carry_flag);  // [RL1] [RL5]
    next_carry  = carry_out(op_code, operand, carry_flag);     // [RL2] [RL6]
  end

  // ==========================================================
  // Flag datapath
  // Only this byte decides zero; a chained wider rotate must not trust it
  always @* begin
    next_zero = is_zero(next_result);  // [RL3] [RL7]
    next_neg  = next_result[MSB];      // [RL4]
  end

  // ==========================================================
  // Register file
  // The rotate writeback is issued after the direct load, so it wins on a clash
  always @(posedge mclk) begin
    if (!nrst) begin
      for (i = 0; i < NREGS; i = i + 1) begin
        general_register_operand[i] <= ALL_ZERO;
      end
    end else begin
      if (wr_en) begin
        general_register_operand[wr_reg] <= wr_data;
      end
      if (take) begin
        general_register_operand[op_reg] <= next_result;  // [RL8]
      end
    end
  end

  // ==========================================================
  // Output registers
  // Read-back lags one cycle: it shows the file as it stood before this edge
  always @(posedge mclk) begin
    if (!nrst) begin
      rd_data <= ALL_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // Result holds until the next rotate
  always @(posedge mclk) begin
    if (!nrst) begin
      result <= ALL_ZERO;
    end else if (take) begin
      result <= next_result;  // [RL1] [RL5]
    end
  end

  // One-cycle pulse per accepted rotate
  always @(posedge mclk) begin
    if (!nrst) begin
      done <= 1'b0;
    end else begin
      done <= take;
    end
  end

  // Carry holds between rotates so the next left-through-carry can use it
  always @(posedge mclk) begin
    if (!nrst) begin
      carry_flag <= 1'b0;
    end else if (take) begin
      carry_flag <= next_carry;  // [RL2] [RL6]
    end
  end

  // Zero flag follows the last byte only
  always @(posedge mclk) begin
    if (!nrst) begin
      zero_flag <= 1'b0;
    end else if (take) begin
      zero_flag <= next_zero;  // [RL3] [RL7]
    end
  end

  // Negative flag is the top bit of the last byte
  always @(posedge mclk) begin
    if (!nrst) begin
      neg_flag <= 1'b0;
    end else if (take) begin
      neg_flag <= next_neg;  // [RL4]
    end
  end

endmodule

/* File: rot_chk.sv */
// Checker for the rotate unit: pulse, flag and carry assertions on the top ports
`timescale 1ns/1ps

module rot_chk (
  input wire       mclk,        // Core clock
  input wire       nrst,        // Synchronous reset, active low
  input wire       op_valid,    // Instruction strobe
  input wire [1:0] op_code,     // Instruction select
  input wire       done,        // Rotate completion pulse
  input wire       carry_flag,  // Carry flag
  input wire       zero_flag,   // Zero flag
  input wire       neg_flag,    // Negative flag
  input wire [7:0] result       // Last rotate result
);

  wire go;

  assign go = op_valid && (op_code != 2'h0);

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Assertions
  take_done_a: assert property (go |=> done) else $error("rotate taken without done pulse");
  idle_done_a: assert property (!go |=> !done) else $error("done pulse without rotate");
  zero_flag_a: assert property (done |-> zero_flag == (result == 8'h00)) else $error("zero flag wrong");
  neg_flag_a: assert property (done |-> neg_flag == result[7]) else $error("negative flag wrong");
  carry_in_a: assert property (go && op_code == 2'h1 |=> result[0] == $past(carry_flag))
    else $error("carry not shifted into bit 0");
  right_carry_a: assert property (go && op_code == 2'h2 |=> carry_flag == result[7])
    else $error("right rotate carry wrong");
  left_carry_a: assert property (go && op_code == 2'h3 |=> carry_flag == result[0])
    else $error("left rotate carry wrong");
  result_hold_a: assert property (!done |-> $stable(result)) else $error("result moved without rotate");

endmodule

bind rotate_left_carry_right_unit rot_chk u_chk (
  .mclk       (mclk),
  .nrst       (nrst),
  .op_valid   (op_valid),
  .op_code    (op_code),
  .done       (done),
  .carry_flag (carry_flag),
  .zero_flag  (zero_flag),
  .neg_flag   (neg_flag),
  .result     (result)
);

/* File: rotate_left_carry_right_unit_test.sv */
// Rotate unit bench: both rotates, the chained left rotate, an ignored strobe, back to back and a load clash
`timescale 1ns/1ps

module rotate_left_carry_right_unit_test;

  localparam HALF_PERIOD = 50;
  // About 50 cycles of tests; the watchdog allows three times that
  localparam LIMIT_NS    = 15000;

  reg        mclk     = 1'b0;
  reg        nrst     = 1'b0;
  reg        op_valid = 1'b0;
  reg  [1:0] op_code  = 2'h0;
  reg  [1:0] op_reg   = 2'h0;
  reg        wr_en    = 1'b0;
  reg  [1:0] wr_reg   = 2'h0;
  reg  [7:0] wr_data  = 8'h00;
  reg  [1:0] rd_reg   = 2'h0;
  wire [7:0] rd_data;
  wire [7:0] result;
  wire       done;
  wire       carry_flag;
  wire       zero_flag;
  wire       neg_flag;
  integer    errors   = 0;
  integer    n_checks = 0;

  rotate_left_carry_right_unit i_dut (
    .mclk       (mclk),
    .nrst       (nrst),
    .op_valid   (op_valid),
    .op_code    (op_code),
    .op_reg     (op_reg),
    .wr_en      (wr_en),
    .wr_reg     (wr_reg),
    .wr_data    (wr_data),
    .rd_reg     (rd_reg),
    .rd_data    (rd_data),
    .result     (result),
    .done       (done),
    .carry_flag (carry_flag),
    .zero_flag  (zero_flag),
    .neg_flag   (neg_flag)
  );

  initial begin
    forever #HALF_PERIOD mclk = ~mclk;
  end

  // ==========================================================
  // Helpers
  task ck;
    input [7:0] seen;
    input [7:0] expected;
    begin
      n_checks = n_checks + 1;
      if (seen !== expected) begin
        errors = errors + 1;
        $display("unexpected at %0t: seen %h, expected %h", $time, seen, expected);
      end
    end
  endtask

  // Load a register, rotate it once, then read it back
  task ro;
    input [1:0] c;
    input [1:0] r;
    input [7:0] d;
    input [7:0] e;
    input [3:0] f;
    begin
      @(negedge mclk);
      wr_en   = 1'b1;
      wr_reg  = r;
      wr_data = d;
      @(negedge mclk);
      wr_en    = 1'b0;
      op_valid = 1'b1;
      op_code  = c;
      op_reg   = r;
      rd_reg   = r;
      @(negedge mclk);
      op_valid = 1'b0;
      ck(result, e);
      ck({4'h0, done, carry_flag, zero_flag, neg_flag}, {4'h0, f});
      @(negedge mclk);
      ck(rd_data, e);
    end
  endtask

  // ==========================================================
  // Scenarios
  // Left through carry: carry feeds bit 0, old bit 7 feeds carry
  task s_rlc;
    begin
      ro(2'h1, 2'h2, 8'hA5, 8'h4A, 4'hC);
      ro(2'h1, 2'h2, 8'h4A, 8'h95, 4'h9);
    end
  endtask

  // Rotate right: old bit 0 goes to bit 7 and to carry
  task s_rr;
    begin
      ro(2'h2, 2'h0, 8'h5A, 8'h2D, 4'h8);
      ro(2'h2, 2'h1, 8'hA5, 8'hD2, 4'hD);
    end
  endtask

  // Low byte nonzero yet zero set: flag sees only the last byte
  task s_chain;
    begin
      ro(2'h3, 2'h0, 8'h01, 8'h02, 4'h8);
      ro(2'h1, 2'h1, 8'h80, 8'h00, 4'hE);
    end
  endtask

  // A strobe with no rotate selected is ignored: no pulse, nothing moves
  task s_none;
    begin
      @(negedge mclk);
      wr_en   = 1'b1;
      wr_reg  = 2'h3;
      wr_data = 8'h81;
      @(negedge mclk);
      wr_en    = 1'b0;
      op_valid = 1'b1;
      op_code  = 2'h0;
      op_reg   = 2'h3;
      rd_reg   = 2'h3;
      @(negedge mclk);
      op_valid = 1'b0;
      ck(result, 8'h00);
      ck({4'h0, done, carry_flag, zero_flag, neg_flag}, 8'h06);
      @(negedge mclk);
      ck(rd_data, 8'h81);
    end
  endtask

  // Back to back: the second rotate sees the first one's register and carry
  task s_back;
    begin
      @(negedge mclk);
      wr_en   = 1'b1;
      wr_reg  = 2'h2;
      wr_data = 8'h43;
      @(negedge mclk);
      wr_en    = 1'b0;
      op_valid = 1'b1;
      op_code  = 2'h1;
      op_reg   = 2'h2;
      rd_reg   = 2'h2;
      @(negedge mclk);
      ck(result, 8'h87);
      ck({4'h0, done, carry_flag, zero_flag, neg_flag}, 8'h09);
      @(negedge mclk);
      op_valid = 1'b0;
      ck(result, 8'h0E);
      ck({4'h0, done, carry_flag, zero_flag, neg_flag}, 8'h0C);
      ck(rd_data, 8'h87);
      @(negedge mclk);
      ck(rd_data, 8'h0E);
    end
  endtask

  // A direct load and a rotate of one register in one cycle: the rotate wins
  task s_collide;
    begin
      @(negedge mclk);
      wr_en   = 1'b1;
      wr_reg  = 2'h1;
      wr_data = 8'h10;
      @(negedge mclk);
      wr_data  = 8'hFF;
      op_valid = 1'b1;
      op_code  = 2'h2;
      op_reg   = 2'h1;
      rd_reg   = 2'h1;
      @(negedge mclk);
      wr_en    = 1'b0;
      op_valid = 1'b0;
      ck(result, 8'h08);
      ck({4'h0, done, carry_flag, zero_flag, neg_flag}, 8'h08);
      @(negedge mclk);
      ck(rd_data, 8'h08);
    end
  endtask

  // ==========================================================
  // Verdict and run control
  task test_done;
    begin
      if (errors == 0 && n_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    s_rlc;
    s_rr;
    s_chain;
    s_none;
    s_back;
    s_collide;
    test_done;
  end

  // Watchdog: a hang counts as a mismatch and closes the run the usual way
  initial begin
    #LIMIT_NS;
    errors = errors + 1;
    test_done;
  end

endmodule
